/* File: current_mode_pwm_softstart.sv */
// Purpose: fixed-frequency current-mode pwm core with soft start and blanking
// Assumes: inputs synchronous to clk_in; sense words already digitised
// Notes: burst level detection and extended blanking counting live elsewhere
`timescale 1ns/1ps
// Functional notes
// - soft start begins when supply passes on-threshold
// - limit level rises in 32 counter steps
// - one soft start step every 300 us
// - soft start ends 10 ms after switch-on
// - every restart attempt reruns full soft start
// - oscillator runs at nominal 100 kHz
// - after soft start, jitter +-4 percent, 4 ms
// - on-time never exceeds 0.75 of period
// - oscillator sets latch; four comparators clear it
// - cleared latch turns gate off at once
// - gate held low below supply off-threshold
// - peak current over threshold ends the pulse
// - sense ignored during blanking after turn-on
// - burst mode enables lower burst current limit
// - slope-dependent threshold for both limits
// - 20 ms persistence before burst or restart
// - overload restart blanking extendable by pin
// - falling below off-threshold resets soft start
// - burst counter held zero unless feedback low
module current_mode_pwm_softstart
  import pwm_core_pkg::*;
#(
  parameter int unsigned SS_STEP_CYC_P = SS_STEP_CYC,
  parameter int unsigned SS_TOTAL_CYC_P = SS_TOTAL_CYC,
  parameter int unsigned BLANK_CYC_P = BLANK_CYC
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire supply_t supply_in,
  input wire sense_t sense_in,
  input wire ctrl_t ctrl_in,
  output logic gate_out,
  output logic soft_start_out,
  output logic burst_mode_out,
  output logic auto_restart_out
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // threshold pulled down by the current slope, floor at zero
  function automatic logic [CS_W-1:0] dyn_thresh(input logic [CS_W-1:0] base,
                                                 input logic [CS_W-1:0] slope);
    logic [CS_W:0] adj;
    adj = {1'b0, slope} << SLOPE_SHIFT;
    dyn_thresh = (adj >= {1'b0, base}) ? '0 : CS_W'({1'b0, base} - adj);
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  mode_t state_r, state_nxt;
  logic [STEP_W-1:0] step_r, step_nxt;
  logic [PRE_W-1:0] ss_pre_r, ss_pre_nxt;
  logic [TOT_W-1:0] ss_tot_r, ss_tot_nxt;
  logic [PH_W-1:0] phase_r, phase_nxt;
  logic signed [7:0] jit_r, jit_nxt;
  logic jit_up_r, jit_up_nxt;
  logic [JPRE_W-1:0] jit_pre_r, jit_pre_nxt;
  logic [LEB_W-1:0] leb_r, leb_nxt;
  logic [CS_W-1:0] cs_prev_r, cs_prev_nxt;
  logic latch_r, latch_nxt;
  logic gate_r, gate_nxt;
  logic burst_r, burst_nxt;
  logic [BLK_W-1:0] burst_cnt_r, burst_cnt_nxt;
  logic [BLK_W-1:0] prot_cnt_r, prot_cnt_nxt;
  // mode flags registered from the next state so the outputs come straight from flops
  logic soft_r, soft_nxt;
  logic restart_r, restart_nxt;

  logic [PH_W-1:0] period, duty_lim;
  logic [CS_W-1:0] slope;
  logic [AMP_W-1:0] amp, ss_level;
  logic blanked, cyc_start, fb_trip, ss_trip, peak_trip, burst_trip, prot_fire;

  // ----------------------------------------
  // comparators and oscillator
  // ----------------------------------------
  always_comb begin
    period = PH_W'(int'(OSC_CYC) + int'(jit_r));
    duty_lim = PH_W'((int'(period) * DUTY_NUM) / DUTY_DEN);
    // >= so a period that shrinks under the running phase still wraps
    cyc_start = (phase_r >= period - PH_W'(1));
    slope = (sense_in.cs > cs_prev_r) ? sense_in.cs - cs_prev_r : '0;
    blanked = (leb_r < (burst_r ? LEB_W'(LEB_BURST_CYC) : LEB_W'(LEB_NORM_CYC)));
    // one spare bit so a full-scale sense word cannot wrap the product
    amp = AMP_W'(({{(AMP_W + 1 - CS_W){1'b0}}, sense_in.cs} * {1'b0, AMP_W'(CS_GAIN_NUM)})
          >> CS_GAIN_SHIFT) + AMP_W'(phase_r >> RAMP_SHIFT);
    ss_level = AMP_W'(step_r * SS_LEVEL_STEP);
    fb_trip = !blanked && (amp >= AMP_W'(sense_in.fb));
    ss_trip = !blanked && (state_r == ST_SOFT) && (amp >= ss_level);
    peak_trip = !blanked && (sense_in.cs >= dyn_thresh(CS_PEAK_THRESH, slope));
    burst_trip = !blanked && burst_r &&
                 (sense_in.cs >= dyn_thresh(CS_BURST_THRESH, slope));
    prot_fire = (ctrl_in.overload || ctrl_in.other_fault) &&
                (prot_cnt_r == BLK_W'(BLANK_CYC_P)) &&
                (!(ctrl_in.overload && ctrl_in.extend_present && !ctrl_in.other_fault) ||
                 ctrl_in.extend_done);
  end

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    step_nxt = step_r;
    ss_pre_nxt = ss_pre_r;
    ss_tot_nxt = ss_tot_r;
    phase_nxt = cyc_start ? '0 : phase_r + PH_W'(1);
    jit_nxt = jit_r;
    jit_up_nxt = jit_up_r;
    jit_pre_nxt = jit_pre_r;
    leb_nxt = (leb_r == '1) ? leb_r : leb_r + LEB_W'(1);
    cs_prev_nxt = sense_in.cs;
    burst_nxt = burst_r;
    burst_cnt_nxt = '0;
    prot_cnt_nxt = '0;
    latch_nxt = latch_r;
    case (state_r)
      ST_OFF: begin
        if (supply_in.above_on) begin
          state_nxt = ST_SOFT;
        end
      end
      ST_SOFT: begin
        ss_tot_nxt = ss_tot_r + TOT_W'(1);
        ss_pre_nxt = ss_pre_r + PRE_W'(1);
        if (ss_pre_r == PRE_W'(SS_STEP_CYC_P - 1)) begin
          ss_pre_nxt = '0;
          if (step_r != SS_STEP_LAST) begin
            step_nxt = step_r + STEP_W'(1);
          end
        end
        if (ss_tot_r == TOT_W'(SS_TOTAL_CYC_P - 1)) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        // jitter only sweeps in normal operation
        jit_pre_nxt = jit_pre_r + JPRE_W'(1);
        if (jit_pre_r == JPRE_W'(JIT_STEP_CYC - 1)) begin
          jit_pre_nxt = '0;
          jit_nxt = jit_up_r ? jit_r + 8'sh01 : jit_r - 8'sh01;
          if (jit_up_r && jit_r == 8'(JIT_DEV - 1)) begin
            jit_up_nxt = 1'b0;
          end else if (!jit_up_r && jit_r == -8'(JIT_DEV - 1)) begin
            jit_up_nxt = 1'b1;
          end
        end
        if (!burst_r && ctrl_in.fb_below_burst) begin
          burst_cnt_nxt = (burst_cnt_r == BLK_W'(BLANK_CYC_P)) ? burst_cnt_r
                          : burst_cnt_r + BLK_W'(1);
          if (burst_cnt_r == BLK_W'(BLANK_CYC_P - 1)) begin
            burst_nxt = 1'b1;
          end
        end
        if (burst_r && ctrl_in.burst_exit) begin
          burst_nxt = 1'b0;
        end
        if (ctrl_in.overload || ctrl_in.other_fault) begin
          prot_cnt_nxt = (prot_cnt_r == BLK_W'(BLANK_CYC_P)) ? prot_cnt_r
                         : prot_cnt_r + BLK_W'(1);
        end
        if (prot_fire) begin
          state_nxt = ST_RESTART;
          burst_nxt = 1'b0;
        end
      end
      ST_RESTART: begin
        if (ctrl_in.restart_attempt) begin
          state_nxt = ST_SOFT;
          step_nxt = '0;
          ss_pre_nxt = '0;
          ss_tot_nxt = '0;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    if (state_r != ST_RUN) begin
      jit_nxt = '0;
      jit_up_nxt = 1'b1;
      jit_pre_nxt = '0;
    end
    // pwm latch: set by the oscillator, cleared by any comparator or the ceiling
    if (cyc_start && (state_r == ST_RUN || (state_r == ST_SOFT && step_r != '0))) begin
      latch_nxt = 1'b1;
      leb_nxt = '0;
    end else if (fb_trip || ss_trip || peak_trip || burst_trip) begin
      latch_nxt = 1'b0;
    end else if (phase_r >= duty_lim - PH_W'(1)) begin
      latch_nxt = 1'b0;
    end
    if (state_nxt == ST_OFF || state_nxt == ST_RESTART) begin
      latch_nxt = 1'b0;
    end
    if (!supply_in.above_off) begin
      state_nxt = ST_OFF;
      step_nxt = '0;
      ss_pre_nxt = '0;
      ss_tot_nxt = '0;
      burst_nxt = 1'b0;
      latch_nxt = 1'b0;
    end
    // gate follows the latch on the same edge, so a clear cuts it at once
    gate_nxt = latch_nxt;
    soft_nxt = (state_nxt == ST_SOFT);
    restart_nxt = (state_nxt == ST_RESTART);
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_r <= ST_OFF;
      step_r <= '0;
      ss_pre_r <= '0;
      ss_tot_r <= '0;
      phase_r <= '0;
      jit_r <= '0;
      jit_up_r <= 1'b1;
      jit_pre_r <= '0;
      leb_r <= '0;
      cs_prev_r <= '0;
      latch_r <= 1'b0;
      gate_r <= 1'b0;
      burst_r <= 1'b0;
      burst_cnt_r <= '0;
      prot_cnt_r <= '0;
      soft_r <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      ss_pre_r <= ss_pre_nxt;
      ss_tot_r <= ss_tot_nxt;
      phase_r <= phase_nxt;
      jit_r <= jit_nxt;
      jit_up_r <= jit_up_nxt;
      jit_pre_r <= jit_pre_nxt;
      leb_r <= leb_nxt;
      cs_prev_r <= cs_prev_nxt;
      latch_r <= latch_nxt;
      gate_r <= gate_nxt;
      burst_r <= burst_nxt;
      burst_cnt_r <= burst_cnt_nxt;
      prot_cnt_r <= prot_cnt_nxt;
      soft_r <= soft_nxt;
      restart_r <= restart_nxt;
    end
  end

  assign gate_out = gate_r;
  assign soft_start_out = soft_r;
  assign burst_mode_out = burst_r;
  assign auto_restart_out = restart_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [PH_W-1:0] on_cnt_r;
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      on_cnt_r <= '0;
    end else begin
      on_cnt_r <= gate_r ? on_cnt_r + PH_W'(1) : '0;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  uvlo_gate_low_a: assert property (!supply_in.above_off |=> !gate_r)
    else $error("gate high after supply fell below off threshold");
  uvlo_ss_reset_a: assert property (!supply_in.above_off |=> state_r == ST_OFF && step_r == '0)
    else $error("soft start not reset on undervoltage");
  duty_ceiling_a: assert property (on_cnt_r <= PH_W'((OSC_CYC + JIT_DEV) * DUTY_NUM / DUTY_DEN))
    else $error("on time above duty ceiling");
  peak_cutoff_a: assert property (gate_r && peak_trip |=> !gate_r)
    else $error("peak trip did not end pulse");
  latch_gate_a: assert property (!latch_r |-> !gate_r)
    else $error("gate on with latch cleared");
  spike_mask_a: assert property ($rose(gate_r) |-> (!peak_trip && !fb_trip)[*8])
    else $error("sense acted inside blanking");
  ss_step_a: assert property (state_r == ST_SOFT && supply_in.above_off
      && ss_pre_r == PRE_W'(SS_STEP_CYC_P - 1) && step_r != SS_STEP_LAST
      |=> step_r == $past(step_r) + STEP_W'(1))
    else $error("soft start step missed");
  ss_end_a: assert property (state_r == ST_SOFT && supply_in.above_off
      && ss_tot_r == TOT_W'(SS_TOTAL_CYC_P - 1) |=> state_r == ST_RUN)
    else $error("soft start did not end on time");
  restart_ss_a: assert property (state_r == ST_RESTART && ctrl_in.restart_attempt
      && supply_in.above_off |=> state_r == ST_SOFT && ss_tot_r == '0)
    else $error("restart did not rerun soft start");
  jitter_span_a: assert property (int'(jit_r) <= int'(JIT_DEV)
      && int'(jit_r) >= -int'(JIT_DEV))
    else $error("jitter out of range");
  jitter_idle_a: assert property (state_r != ST_RUN |=> jit_r == '0)
    else $error("jitter active outside normal run");
  burst_entry_a: assert property ($rose(burst_r) |-> $past(burst_cnt_r)
      == BLK_W'(BLANK_CYC_P - 1))
    else $error("burst entered without full blanking");
  burst_cutoff_a: assert property (gate_r && burst_trip |=> !gate_r)
    else $error("burst limit did not end pulse");
  ss_entry_a: assert property (state_r == ST_OFF && supply_in.above_on
      && supply_in.above_off |=> state_r == ST_SOFT)
    else $error("soft start not entered at switch-on");

  run_cov_c: cover property (state_r == ST_SOFT ##1 state_r == ST_RUN);
  burst_cov_c: cover property ($rose(burst_r));
  restart_cov_c: cover property (state_r == ST_RESTART ##1 state_r == ST_SOFT);
endmodule // current_mode_pwm_softstart

/* File: pwm_core_pkg.sv */
// Purpose: shared constants and carriers for the current-mode pwm core
// Assumes: 200 MHz system clock, comparator levels sampled as digital words
// Notes: long counts are also module parameters so simulation can shorten them
package pwm_core_pkg;
  // ----------------------------------------
  // time base
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1_000;
  localparam int unsigned OSC_HZ = 100_000;
  localparam int unsigned OSC_CYC = CLK_HZ / OSC_HZ;
  localparam int unsigned JIT_PCT = 4;
  localparam int unsigned JIT_DEV = OSC_CYC * JIT_PCT / 100;
  localparam int unsigned JIT_PERIOD_MS = 4;
  localparam int unsigned JIT_PERIOD_CYC = JIT_PERIOD_MS * CLK_PER_MS;
  // triangle sweep: four deviations' worth of steps per jitter period
  localparam int unsigned JIT_STEP_CYC = JIT_PERIOD_CYC / (4 * JIT_DEV);
  localparam int unsigned DUTY_NUM = 3;
  localparam int unsigned DUTY_DEN = 4;
  localparam int unsigned SS_STEPS = 32;
  localparam int unsigned SS_STEP_US = 300;
  localparam int unsigned SS_STEP_CYC = SS_STEP_US * CLK_PER_US;
  localparam int unsigned SS_TOTAL_MS = 10;
  localparam int unsigned SS_TOTAL_CYC = SS_TOTAL_MS * CLK_PER_MS;
  localparam int unsigned BLANK_MS = 20;
  localparam int unsigned BLANK_CYC = BLANK_MS * CLK_PER_MS;
  localparam int unsigned LEB_NORM_NS = 220;
  localparam int unsigned LEB_BURST_NS = 180;
  localparam int unsigned LEB_NORM_CYC = LEB_NORM_NS * CLK_PER_US / 1000;
  localparam int unsigned LEB_BURST_CYC = LEB_BURST_NS * CLK_PER_US / 1000;
  // ----------------------------------------
  // widths and levels
  // ----------------------------------------
  localparam int unsigned PH_W = 12;
  localparam int unsigned CS_W = 10;
  localparam int unsigned AMP_W = 13;
  localparam int unsigned LEB_W = 6;
  localparam int unsigned STEP_W = 5;
  localparam int unsigned PRE_W = 16;
  localparam int unsigned TOT_W = 21;
  localparam int unsigned BLK_W = 22;
  localparam int unsigned JPRE_W = 12;
  localparam int unsigned CS_GAIN_NUM = 13;
  localparam int unsigned CS_GAIN_SHIFT = 2;
  localparam int unsigned RAMP_SHIFT = 1;
  localparam int unsigned SLOPE_SHIFT = 1;
  localparam logic [CS_W-1:0] CS_PEAK_THRESH = 10'h200;
  localparam logic [CS_W-1:0] CS_BURST_THRESH = 10'h0C0;
  localparam logic [AMP_W-1:0] SS_LEVEL_STEP = 13'h0100;
  localparam logic [STEP_W-1:0] SS_STEP_LAST = 5'(SS_STEPS - 1);
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [CS_W-1:0] cs;
    logic [CS_W-1:0] fb;
  } sense_t;
  typedef struct packed {
    logic above_on;
    logic above_off;
  } supply_t;
  typedef struct packed {
    logic fb_below_burst;
    logic burst_exit;
    logic overload;
    logic other_fault;
    logic extend_present;
    logic extend_done;
    logic restart_attempt;
  } ctrl_t;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_SOFT = 2'b01,
    ST_RUN = 2'b10,
    ST_RESTART = 2'b11
  } mode_t;
endpackage

/* File: sense_network_model.sv */
// Purpose: behavioural current sense network behind the power switch
// Assumes: sense ramps by a fixed slope each clock while the gate is on
// Notes: the sense resistor pulls the line to zero once the gate is off
`timescale 1ns/1ps
module sense_network_model
  import pwm_core_pkg::*;
(
  input wire logic clk_in,
  input wire logic gate_in,
  input wire logic [CS_W-1:0] slope_in,
  output logic [CS_W-1:0] cs_out
);
  logic [CS_W:0] sum;
  assign sum = {1'b0, cs_out} + {1'b0, slope_in};
  initial cs_out = '0;
  // saturate rather than wrap, a wrapped ramp would hide a missed trip
  always @(posedge clk_in) begin
    if (gate_in !== 1'b1) begin
      cs_out <= '0;
    end else begin
      cs_out <= sum[CS_W] ? '1 : sum[CS_W-1:0];
    end
  end
endmodule // sense_network_model

/* File: current_mode_pwm_softstart_tb.sv */
// Purpose: self-checking bench for the current-mode pwm core
// Assumes: shortened soft start and blanking counts via parameters
// Notes: pulse widths compared with an integer model, small phase slack
`timescale 1ns/1ps
module current_mode_pwm_softstart_tb;
  import pwm_core_pkg::*;
  localparam int STEP = 20;
  localparam int TOT = 700;
  localparam int BLK = 50;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  supply_t supply_in = '0;
  ctrl_t ctrl_in = '0;
  logic [CS_W-1:0] fb = '1;
  logic [CS_W-1:0] slope = '0;
  logic [CS_W-1:0] cs;
  logic gate_out;
  logic soft_start_out;
  logic burst_mode_out;
  logic auto_restart_out;
  int errors = 0;
  int num_checks = 0;
  int n;
  int w;
  always #2.5 clk_in = ~clk_in;
  sense_network_model u_net(.clk_in(clk_in), .gate_in(gate_out), .slope_in(slope), .cs_out(cs));
  current_mode_pwm_softstart #(.SS_STEP_CYC_P(STEP), .SS_TOTAL_CYC_P(TOT), .BLANK_CYC_P(BLK))
    u_dut(.clk_in(clk_in), .reset_n_in(reset_n_in), .supply_in(supply_in),
      .sense_in(sense_t'({cs, fb})), .ctrl_in(ctrl_in), .gate_out(gate_out),
      .soft_start_out(soft_start_out), .burst_mode_out(burst_mode_out),
      .auto_restart_out(auto_restart_out));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic wait_sig(ref logic s, input logic v, input int lim, output int c);
    c = 0;
    while (s !== v && c < lim) begin
      @(posedge clk_in);
      #1;
      c++;
    end
  endtask
  // cycles of gate high for a ramp of slope s against feedback f
  function automatic int model_width(int f, int s, bit b);
    int c;
    for (int k = 0; k < 1500; k++) begin
      c = (s * k > (1 << CS_W) - 1) ? (1 << CS_W) - 1 : s * k;
      if (k >= (b ? LEB_BURST_CYC : LEB_NORM_CYC) && (((c * CS_GAIN_NUM) >> CS_GAIN_SHIFT)
          + (k >> RAMP_SHIFT) >= f || c >= int'(CS_PEAK_THRESH) - (s << SLOPE_SHIFT)
          || (b && c >= int'(CS_BURST_THRESH) - (s << SLOPE_SHIFT)))) begin
        return k + 1;
      end
    end
    return 1500;
  endfunction
  task automatic pulse(input bit b);
    int f;
    int s;
    int m;
    @(posedge clk_in);
    f = 300 + $urandom_range(723);
    s = 1 + $urandom_range(7);
    fb <= f[CS_W-1:0];
    slope <= s[CS_W-1:0];
    wait_sig(gate_out, 1'b0, 2100, n);
    wait_sig(gate_out, 1'b1, 2100, n);
    wait_sig(gate_out, 1'b0, 1600, w);
    m = model_width(f, s, b);
    check(w >= m - 4 && w <= m + 4, "pulse width");
    wait_sig(gate_out, 1'b1, 2100, n);
    check(n + w >= OSC_CYC - JIT_DEV - 2 && n + w <= OSC_CYC + JIT_DEV + 2, "period");
  endtask
  task automatic complete_run();
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h47fc));
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    #1;
    check({gate_out, soft_start_out, burst_mode_out, auto_restart_out} === 4'h0, "reset");
    for (int r = 0; r < 2; r++) begin
      @(posedge clk_in);
      supply_in <= '{above_on: 1'b1, above_off: 1'b1};
      wait_sig(soft_start_out, 1'b1, 4, n);
      check(soft_start_out === 1'b1 && n <= 2, "soft start entry");
      wait_sig(soft_start_out, 1'b0, TOT + 10, n);
      check(n >= TOT - 2 && n <= TOT + 2, "soft start length");
      if (r == 0) begin
        for (int i = 0; i < 4; i++) pulse(1'b0);
        // a short dip must restart the persistence count from zero
        @(posedge clk_in);
        ctrl_in.fb_below_burst <= 1'b1;
        repeat (BLK - 20) @(posedge clk_in);
        ctrl_in.fb_below_burst <= 1'b0;
        @(posedge clk_in);
        ctrl_in.fb_below_burst <= 1'b1;
        wait_sig(burst_mode_out, 1'b1, BLK + 20, n);
        check(n >= BLK - 1 && n <= BLK + 3, "burst entry");
        pulse(1'b1);
        pulse(1'b1);
        @(posedge clk_in);
        ctrl_in <= '{burst_exit: 1'b1, default: 1'b0};
        @(posedge clk_in);
        ctrl_in <= '0;
        wait_sig(burst_mode_out, 1'b0, 4, n);
        check(burst_mode_out === 1'b0, "burst exit");
        @(posedge clk_in);
        ctrl_in <= '{overload: 1'b1, extend_present: 1'b1, default: 1'b0};
        repeat (3 * BLK) @(posedge clk_in);
        #1;
        check(auto_restart_out === 1'b0, "early restart");
        @(posedge clk_in);
        ctrl_in.extend_done <= 1'b1;
        wait_sig(auto_restart_out, 1'b1, 4, n);
        check(auto_restart_out === 1'b1 && gate_out === 1'b0, "extended restart");
        @(posedge clk_in);
        ctrl_in <= '{restart_attempt: 1'b1, default: 1'b0};
        @(posedge clk_in);
        ctrl_in <= '0;
        wait_sig(soft_start_out, 1'b1, 4, n);
        check(soft_start_out === 1'b1, "restart soft start");
        wait_sig(soft_start_out, 1'b0, TOT + 10, n);
        check(n >= TOT - 4 && n <= TOT + 2, "restart soft length");
        @(posedge clk_in);
        ctrl_in <= '{overload: 1'b1, default: 1'b0};
        wait_sig(auto_restart_out, 1'b1, BLK + 20, n);
        check(n >= BLK && n <= BLK + 3, "overload blanking");
      end
      @(posedge clk_in);
      ctrl_in <= '0;
      supply_in <= '0;
      wait_sig(auto_restart_out, 1'b0, 3, n);
      @(posedge clk_in);
      #1;
      check({gate_out, soft_start_out, burst_mode_out, auto_restart_out} === 4'h0, "undervoltage");
    end
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    errors++;
    complete_run();
  end
endmodule // current_mode_pwm_softstart_tb
